// File: hw/cax_pkg.sv
// package for the core arithmetic subset datapath
// What this block does
// (RULE1) pointer add sign-extends a 6-bit literal (-32..31), adds it to pointer 0 or 1, flags kept.
// (RULE2) pointer sums wrap modulo 2^16 past either bound.
// (RULE3) AND-literal ands the accumulator with an 8-bit value into the accumulator, zero flag only.
// (RULE4) add-literal adds an 8-bit value into the accumulator, updating carry, nibble and zero.
// (RULE5) add-register adds accumulator and file reg (7-bit address), dest bit picks target.
// (RULE6) AND-register ands accumulator and file reg, dest bit picks target, zero flag only.
// (RULE7) arithmetic shift right keeps bit 7, old bit 0 goes to carry, updates carry and zero.
// (RULE8) add-with-carry sums accumulator, file reg and carry, routed by dest bit, C/DC/Z.
// (RULE9) bit clear zeroes bit 0..7 of the file reg, other bits and all flags kept.
// (RULE10) nibble flag is the carry out of bit 3; zero flag is set when the result is zero.
package cax_pkg;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  localparam int PTR_W    = 16;
  localparam int LIT6_W   = 6;
  localparam int NIB_BIT  = 4;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;

  typedef enum logic [3:0] {
    CAX_NOP                     = 4'h0,
    CAX_POINTER_ADD_LITERAL     = 4'h1,
    CAX_AND_LITERAL_ACC         = 4'h2,
    CAX_ADD_LITERAL_ACC         = 4'h3,
    CAX_ADD_ACC_FILE            = 4'h4,
    CAX_AND_ACC_FILE            = 4'h5,
    CAX_ARITH_SHIFT_RIGHT       = 4'h6,
    CAX_ADD_ACC_FILE_WITH_CARRY = 4'h7,
    CAX_BIT_CLEAR_FILE          = 4'h8
  } cax_op_t;

  typedef struct packed {
    cax_op_t            op;
    logic [7:0]         literal;
    logic [6:0]         faddr;
    logic               dest;
    logic [2:0]         bit_idx;
    logic               ptr_sel;
  } cax_instr_t;

  typedef struct packed {
    logic carry;
    logic nibble_overflow_bit;
    logic zero;
  } cax_flags_t;
endpackage

// File: hw/cax_file_mem.sv
// file register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module cax_file_mem
  import cax_pkg::*;
#(
  parameter int AW = FADDR_W,
  parameter int DW = DATA_W
)(
  input  wire logic          clk,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// File: hw/cax_alu.sv
// execution datapath for the arithmetic, logic and pointer instruction subset
`timescale 1ns/100ps
`default_nettype none
module cax_alu
  import cax_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         instr_valid,
  input  wire cax_instr_t   instr,
  output var  logic         busy,
  output var  logic         done,
  output var  logic [7:0]   acc,
  output var  cax_flags_t   flags,
  output var  logic [15:0]  pointer0,
  output var  logic [15:0]  pointer1
);
  typedef enum logic [1:0] {
    CAX_IDLE  = 2'b00,
    CAX_FETCH = 2'b01,
    CAX_EXEC  = 2'b10
  } cax_state_t;

  cax_state_t state_r;
  cax_instr_t ins_r;
  logic [7:0] fdata;
  logic       we_r;
  logic [6:0] waddr_r;
  logic [7:0] wdata_r;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic       uses_file;
  logic [6:0] raddr;

  // one add feeds all three add forms so carry and nibble are computed alike
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
                                      input logic cin);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  cax_file_mem #(.AW(FADDR_W), .DW(DATA_W)) u_mem (
    .clk   (clk),
    .raddr (raddr),
    .rdata (fdata),
    .we    (we_r),
    .waddr (waddr_r),
    .wdata (wdata_r)
  );

  // once taken, the held copy addresses the memory, so the caller may move the request lines
  assign raddr = (state_r == CAX_IDLE) ? instr.faddr : ins_r.faddr;

  assign uses_file = !(instr.op inside {CAX_NOP, CAX_POINTER_ADD_LITERAL,
                                        CAX_AND_LITERAL_ACC, CAX_ADD_LITERAL_ACC});

  always_comb
  begin
    logic [7:0] opnd;
    logic       cin;
    opnd = (ins_r.op == CAX_ADD_LITERAL_ACC) ? ins_r.literal : fdata;
    cin  = (ins_r.op == CAX_ADD_ACC_FILE_WITH_CARRY) ? flags.carry : 1'b0; // RULE8
    sum9 = add9(acc, opnd, cin);
    sum5 = add5(acc[3:0], opnd[3:0], cin); // RULE10
    case (ins_r.op)
      CAX_AND_LITERAL_ACC:   res = acc & ins_r.literal; // RULE3
      CAX_AND_ACC_FILE:      res = acc & fdata; // RULE6
      CAX_ARITH_SHIFT_RIGHT: res = {fdata[7], fdata[7:1]}; // RULE7
      CAX_BIT_CLEAR_FILE:    res = fdata & ~(8'h01 << ins_r.bit_idx); // RULE9
      default:               res = sum9[7:0]; // RULE4 RULE5
    endcase
  end

  // file operands need one cycle for the memory read, literal ops skip it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= CAX_IDLE;
      ins_r   <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_r)
        CAX_IDLE:
        begin
          if (instr_valid)
          begin
            ins_r   <= instr;
            busy    <= 1'b1;
            state_r <= uses_file ? CAX_FETCH : CAX_EXEC;
          end
        end
        CAX_FETCH: state_r <= CAX_EXEC;
        CAX_EXEC:
        begin
          busy    <= 1'b0;
          done    <= 1'b1;
          state_r <= CAX_IDLE;
        end
        default: state_r <= CAX_IDLE;
      endcase
    end
  end

  // destination routing
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc     <= ACC_RST;
      we_r    <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
    end
    else
    begin
      we_r <= 1'b0;
      if (state_r == CAX_EXEC)
      begin
        case (ins_r.op)
          CAX_AND_LITERAL_ACC, CAX_ADD_LITERAL_ACC: acc <= res; // RULE3 RULE4
          CAX_ADD_ACC_FILE, CAX_AND_ACC_FILE, CAX_ARITH_SHIFT_RIGHT,
          CAX_ADD_ACC_FILE_WITH_CARRY:
          begin
            if (ins_r.dest) // RULE5 RULE6 RULE7 RULE8
            begin
              we_r    <= 1'b1;
              waddr_r <= ins_r.faddr;
              wdata_r <= res;
            end
            else
            begin
              acc <= res;
            end
          end
          CAX_BIT_CLEAR_FILE: // RULE9
          begin
            we_r    <= 1'b1;
            waddr_r <= ins_r.faddr;
            wdata_r <= res;
          end
          default: ;
        endcase
      end
    end
  end

  // status flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flags <= '0;
    end
    else if (state_r == CAX_EXEC)
    begin
      case (ins_r.op)
        CAX_AND_LITERAL_ACC, CAX_AND_ACC_FILE:
          flags.zero <= (res == 8'h00); // RULE3 RULE6
        CAX_ADD_LITERAL_ACC, CAX_ADD_ACC_FILE, CAX_ADD_ACC_FILE_WITH_CARRY:
        begin
          flags.carry               <= sum9[8]; // RULE4 RULE5 RULE8
          flags.nibble_overflow_bit <= sum5[NIB_BIT]; // RULE10
          flags.zero                <= (res == 8'h00); // RULE10
        end
        CAX_ARITH_SHIFT_RIGHT:
        begin
          flags.carry <= fdata[0]; // RULE7
          flags.zero  <= (res == 8'h00); // RULE7
        end
        default: ;
      endcase
    end
  end

  // pointer add: 16-bit sum drops the carry, so both bounds wrap
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pointer0 <= PTR_RST;
      pointer1 <= PTR_RST;
    end
    else if (state_r == CAX_EXEC && ins_r.op == CAX_POINTER_ADD_LITERAL)
    begin
      if (ins_r.ptr_sel) // RULE1
        pointer1 <= pointer1 + {{10{ins_r.literal[5]}}, ins_r.literal[5:0]}; // RULE1 RULE2
      else
        pointer0 <= pointer0 + {{10{ins_r.literal[5]}}, ins_r.literal[5:0]}; // RULE1 RULE2
    end
  end

  property p_ptr_add;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_POINTER_ADD_LITERAL && !ins_r.ptr_sel) |=>
      pointer0 == 16'($past(pointer0) + {{10{$past(ins_r.literal[5])}},
                                         $past(ins_r.literal[5:0])});
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong"); // RULE1

  property p_ptr_flags;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op inside {CAX_POINTER_ADD_LITERAL, CAX_BIT_CLEAR_FILE})
      |=> $stable(flags);
  endproperty
  a_ptr_flags: assert property (p_ptr_flags) else $error("flags changed"); // RULE9

  property p_and_lit;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_AND_LITERAL_ACC) |=>
      acc == ($past(acc) & $past(ins_r.literal)) && $stable(flags.carry)
      && flags.zero == (acc == 8'h00);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong"); // RULE3

  property p_add_lit;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_ADD_LITERAL_ACC) |=>
      {flags.carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(ins_r.literal)};
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal wrong"); // RULE4

  property p_dest_file;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_ADD_ACC_FILE && ins_r.dest) |=>
      we_r && $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest routing wrong"); // RULE5

  property p_and_file;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_AND_ACC_FILE && !ins_r.dest) |=>
      !we_r && flags.zero == (acc == 8'h00) && $stable(flags.carry);
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file wrong"); // RULE6

  property p_asr;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_ARITH_SHIFT_RIGHT) |=>
      flags.carry == $past(fdata[0]) && (we_r || acc[7] == $past(fdata[7]));
  endproperty
  a_asr: assert property (p_asr) else $error("shift wrong"); // RULE7

  property p_addc;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_ADD_ACC_FILE_WITH_CARRY && !ins_r.dest) |=>
      {flags.carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(fdata)}
                            + {8'h00, $past(flags.carry)};
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong"); // RULE8

  property p_nibble;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_ADD_LITERAL_ACC) |=>
      flags.nibble_overflow_bit ==
        (5'({1'b0, $past(acc[3:0])} + {1'b0, $past(ins_r.literal[3:0])}) > 5'h0f);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble flag wrong"); // RULE10

  property p_done;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_IDLE && instr_valid) |-> ##[1:3] done;
  endproperty
  a_done: assert property (p_done) else $error("no completion"); // RULE4

  property p_ptr1_add;
    @(posedge clk) disable iff (reset)
    (state_r == CAX_EXEC && ins_r.op == CAX_POINTER_ADD_LITERAL && ins_r.ptr_sel) |=>
      pointer1 == 16'($past(pointer1) + {{10{$past(ins_r.literal[5])}},
                                         $past(ins_r.literal[5:0])}) && $stable(pointer0);
  endproperty
  a_ptr1_add: assert property (p_ptr1_add) else $error("pointer wrap wrong"); // RULE2

  c_ptr_wrap: cover property (@(posedge clk) disable iff (reset)
    state_r == CAX_EXEC && ins_r.op == CAX_POINTER_ADD_LITERAL && pointer0 == 16'hffff);
  c_addc_carry: cover property (@(posedge clk) disable iff (reset)
    state_r == CAX_EXEC && ins_r.op == CAX_ADD_ACC_FILE_WITH_CARRY && flags.carry);
  c_bclr: cover property (@(posedge clk) disable iff (reset)
    state_r == CAX_EXEC && ins_r.op == CAX_BIT_CLEAR_FILE);
endmodule
`default_nettype wire

// File: dv/cax_alu_bench.sv
// self-checking testbench for the arithmetic subset datapath
`timescale 1ns/100ps
`default_nettype none
module cax_alu_bench
  import cax_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        instr_valid;
  cax_instr_t  instr;
  logic        busy;
  logic        done;
  logic [7:0]  acc;
  cax_flags_t  flags;
  logic [15:0] pointer0;
  logic [15:0] pointer1;
  int          fails;
  int          total_checks;
  logic [7:0]  m_acc;
  logic        m_c;
  logic        m_dc;
  logic        m_z;
  logic [15:0] m_p [2];
  logic [7:0]  m_mem [128];

  cax_alu cax_alu_inst (
    .clk         (clk),
    .reset       (reset),
    .instr_valid (instr_valid),
    .instr       (instr),
    .busy        (busy),
    .done        (done),
    .acc         (acc),
    .flags       (flags),
    .pointer0    (pointer0),
    .pointer1    (pointer1)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_all();
    chk("acc", {8'h00, m_acc}, {8'h00, acc});
    chk("flags", {13'h0000, m_c, m_dc, m_z}, {13'h0000, flags});
    chk("pointer0", m_p[0], pointer0);
    chk("pointer1", m_p[1], pointer1);
  endtask

  task automatic model_reset();
    m_acc = 8'h00;
    {m_c, m_dc, m_z} = 3'h0;
    m_p[0] = 16'h0000;
    m_p[1] = 16'h0000;
  endtask

  // entered at a falling edge; the bench model is advanced before the request goes out
  task automatic run(input cax_op_t op, input logic [7:0] lit, input logic [6:0] fa,
                     input logic d, input logic [2:0] bi, input logic ps, input logic intrude);
    logic [7:0] m;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] h;
    logic       cin;
    int         n;
    m = (op == CAX_ADD_LITERAL_ACC) ? lit : m_mem[fa];
    r = m_acc;
    cin = (op == CAX_ADD_ACC_FILE_WITH_CARRY) & m_c;
    s = {1'b0, m_acc} + {1'b0, m} + {8'h00, cin};
    h = {1'b0, m_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    case (op)
      CAX_POINTER_ADD_LITERAL: m_p[ps] = m_p[ps] + {{10{lit[5]}}, lit[5:0]};
      CAX_AND_LITERAL_ACC:     r = m_acc & lit;
      CAX_AND_ACC_FILE:        r = m_acc & m;
      CAX_ARITH_SHIFT_RIGHT:   {r, m_c} = {m[7], m};
      CAX_BIT_CLEAR_FILE:      m_mem[fa][bi] = 1'b0;
      CAX_ADD_LITERAL_ACC, CAX_ADD_ACC_FILE, CAX_ADD_ACC_FILE_WITH_CARRY:
        {m_c, m_dc, r} = {s[8], h[4], s[7:0]};
      default: ;
    endcase
    if (op >= CAX_AND_LITERAL_ACC && op <= CAX_ADD_ACC_FILE_WITH_CARRY)
    begin
      m_z = (r == 8'h00);
      if (d && op >= CAX_ADD_ACC_FILE)
        m_mem[fa] = r;
      else
        m_acc = r;
    end
    instr = '{op, lit, fa, d, bi, ps};
    instr_valid = 1'b1;
    @(negedge clk);
    chk("busy", 16'h0001, {15'h0000, busy});
    instr_valid = intrude;
    // a stray add while busy would show up in acc if it were taken
    instr.op = CAX_ADD_LITERAL_ACC;
    instr.faddr = ~fa;
    for (n = 0; n < 8 && done !== 1'b1; n++)
    begin
      @(negedge clk);
      if (n == 0 && intrude)
        instr_valid = 1'b0;
    end
    if (done !== 1'b1)
    begin
      fails++;
      close_out();
    end
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("cycles", (op inside {CAX_POINTER_ADD_LITERAL, CAX_AND_LITERAL_ACC,
                              CAX_ADD_LITERAL_ACC}) ? 16'h0001 : 16'h0002, 16'(n));
    chk_all();
    if (intrude)
      @(negedge clk);
  endtask

  task automatic lit_op(input cax_op_t op, input logic [7:0] v);
    run(op, v, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
  endtask

  task automatic file_op(input cax_op_t op, input logic [6:0] fa, input logic d);
    run(op, 8'h00, fa, d, 3'h0, 1'b0, 1'b0);
  endtask

  task automatic t_literal();
    lit_op(CAX_ADD_LITERAL_ACC, 8'hFF);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h89);
    run(CAX_AND_LITERAL_ACC, 8'h77, 7'h00, 1'b0, 3'h0, 1'b0, 1'b1);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h08);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h08);
  endtask

  task automatic t_pointer();
    run(CAX_POINTER_ADD_LITERAL, 8'hE0, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    run(CAX_POINTER_ADD_LITERAL, 8'h1F, 7'h00, 1'b0, 3'h0, 1'b1, 1'b0);
    run(CAX_POINTER_ADD_LITERAL, 8'h1F, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    run(CAX_POINTER_ADD_LITERAL, 8'h01, 7'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    run(CAX_POINTER_ADD_LITERAL, 8'h7F, 7'h00, 1'b0, 3'h0, 1'b1, 1'b0);
  endtask

  task automatic t_file();
    // file memory powers up unknown, so both used cells are cleared bit by bit first
    for (int i = 0; i < 8; i++)
    begin
      run(CAX_BIT_CLEAR_FILE, 8'h00, 7'h7F, 1'b0, 3'(i), 1'b0, 1'b0);
      run(CAX_BIT_CLEAR_FILE, 8'h00, 7'h00, 1'b1, 3'(i), 1'b0, 1'b0);
    end
    file_op(CAX_ADD_ACC_FILE, 7'h7F, 1'b1);
    file_op(CAX_ADD_ACC_FILE, 7'h7F, 1'b0);
    file_op(CAX_AND_ACC_FILE, 7'h7F, 1'b1);
    file_op(CAX_AND_ACC_FILE, 7'h7F, 1'b0);
    lit_op(CAX_AND_LITERAL_ACC, 8'h00);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h81);
    file_op(CAX_ADD_ACC_FILE, 7'h00, 1'b1);
    file_op(CAX_ARITH_SHIFT_RIGHT, 7'h00, 1'b1);
    file_op(CAX_ARITH_SHIFT_RIGHT, 7'h00, 1'b0);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h20);
    file_op(CAX_ADD_ACC_FILE_WITH_CARRY, 7'h00, 1'b0);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h3F);
    file_op(CAX_ADD_ACC_FILE_WITH_CARRY, 7'h7F, 1'b1);
    run(CAX_BIT_CLEAR_FILE, 8'h00, 7'h00, 1'b0, 3'h7, 1'b0, 1'b0);
    file_op(CAX_ADD_ACC_FILE_WITH_CARRY, 7'h00, 1'b0);
    file_op(CAX_ADD_ACC_FILE, 7'h7F, 1'b0);
  endtask

  task automatic t_reset_mid();
    instr = '{CAX_ADD_LITERAL_ACC, 8'h55, 7'h00, 1'b0, 3'h0, 1'b0};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    reset = 1'b1;
    model_reset();
    @(negedge clk);
    chk_all();
    reset = 1'b0;
    @(negedge clk);
    lit_op(CAX_ADD_LITERAL_ACC, 8'h00);
  endtask

  initial
  begin
    fails = 0;
    total_checks = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = '{CAX_NOP, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0};
    model_reset();
    repeat (6) @(negedge clk);
    chk_all();
    reset = 1'b0;
    @(negedge clk);
    t_literal();
    t_pointer();
    t_file();
    t_reset_mid();
    close_out();
  end
endmodule
`default_nettype wire
